// ==== design/pms_power_mode_sequencer.sv ====
// Purpose: power mode control, lockouts and pre-regulator selection
// Assumes: comparator inputs already synchronous to mclk
// Notes: long delays are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module pms_power_mode_sequencer #(
	parameter int SLEEP_RST_CYC  = pms_pkg::SLEEP_RST_CYC,
	parameter int WAKE_LOW_CYC   = pms_pkg::WAKE_LOW_CYC,
	parameter int CAP_PERIOD_CYC = pms_pkg::CAP_PERIOD_CYC,
	parameter int CAP_OFF_CYC    = pms_pkg::CAP_OFF_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// Analog comparators
	input  wire logic       wakeHigh,
	input  wire logic       batteryAboveLockout,
	input  wire logic       boostGood,
	input  wire logic       stepDownGoodCmp,
	input  wire logic       internalReset,
	// Command from host
	input  wire logic       convOffCmd,
	// Converter and supply control
	output logic            convEnable,
	output logic            coreSupplyEnable,
	output logic            logicRegEnable,
	output logic            sleepResetActive,
	output logic            sleepMode_n,
	output logic            offPending,
	output logic            ignitionFlag,
	output logic [1:0]      switchPreregSel,
	output logic [1:0]      logicPreregSel
);
	logic       wakeRun;
	logic       wakeDelayDone;
	logic       lowRun;
	logic       lowDone;
	logic       pend_reg;
	logic       off_reg;
	logic       off_next;
	logic       lock_reg;
	logic       capWrap;
	logic       capPhase;
	logic       en_reg;
	logic       core_reg;
	logic       logicEn_reg;
	logic       ign_reg;
	logic [1:0] hiSel_reg;
	logic [1:0] loSel_reg;

	// Once released, sleep reset stays released through wake lows until off
	assign wakeRun = (wakeHigh || wakeDelayDone) && !off_reg;
	pms_timer #(.LIMIT(SLEEP_RST_CYC)) uSleepDly (
		.mclk    (mclk),
		.reset_n (reset_n),
		.run     (wakeRun),
		.done    (wakeDelayDone)
	);
	// Counter clears as soon as wake returns high
	assign lowRun = pend_reg && !wakeHigh;
	pms_timer #(.LIMIT(WAKE_LOW_CYC)) uLowDly (
		.mclk    (mclk),
		.reset_n (reset_n),
		.run     (lowRun),
		.done    (lowDone)
	);
	// Period free-runs; off window is its first few cycles
	pms_timer #(.LIMIT(CAP_PERIOD_CYC - 1)) uCapPer (
		.mclk    (mclk),
		.reset_n (reset_n),
		.run     (!capWrap),
		.done    (capWrap)
	);
	pms_timer #(.LIMIT(CAP_OFF_CYC)) uCapOff (
		.mclk    (mclk),
		.reset_n (reset_n),
		.run     (!capWrap),
		.done    (capPhase)
	);

	// Glitch under 1 ms leaves the command pending, not executed
	assign off_next = off_reg ? wakeHigh ? 1'b0 : 1'b1
	                          : (lowDone && !wakeHigh);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pend_reg <= 1'b0;
			off_reg  <= 1'b0;
		end else begin
			off_reg <= off_next;
			if (off_next)
				pend_reg <= 1'b0;
			else if (convOffCmd && wakeDelayDone && !off_reg)
				pend_reg <= 1'b1;
		end
	end

	// Stays locked until internal reset re-selects the mux
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			lock_reg <= 1'b0;
		else if (internalReset)
			lock_reg <= 1'b0;
		else if (!stepDownGoodCmp)
			lock_reg <= 1'b1;
	end

	wire sleepNow   = !(wakeDelayDone && !off_reg);
	wire sleepSig_n = !sleepNow;
	// Wake starts the converters; a wake low alone never stops them
	wire enNext     = batteryAboveLockout && (wakeHigh || en_reg) && !off_reg;
	wire coreNext   = enNext && stepDownGoodCmp && !lock_reg;
	// Sleep-mode column uses the active-low signal as printed
	wire [1:0] hiSelNext = internalReset ? pms_pkg::POS_0
	                     : !sleepSig_n ? pms_pkg::POS_1
	                     : boostGood ? pms_pkg::POS_2 : pms_pkg::POS_1;
	wire [1:0] loSelNext = sleepSig_n ? (stepDownGoodCmp ? pms_pkg::POS_2 : pms_pkg::POS_1)
	                     : wakeHigh ? pms_pkg::POS_1 : pms_pkg::POS_0;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_reg      <= 1'b0;
			core_reg    <= 1'b0;
			logicEn_reg <= 1'b1;
			ign_reg     <= 1'b0;
			hiSel_reg   <= pms_pkg::POS_0;
			loSel_reg   <= pms_pkg::POS_0;
		end else begin
			en_reg      <= enNext;
			core_reg    <= coreNext;
			logicEn_reg <= capPhase;
			ign_reg     <= batteryAboveLockout;
			hiSel_reg   <= hiSelNext;
			loSel_reg   <= loSelNext;
		end
	end

	assign convEnable       = en_reg;
	assign coreSupplyEnable = core_reg;
	assign logicRegEnable   = logicEn_reg;
	assign sleepResetActive = sleepNow;
	assign sleepMode_n      = sleepSig_n;
	assign offPending       = pend_reg;
	assign ignitionFlag     = ign_reg;
	assign switchPreregSel  = hiSel_reg;
	assign logicPreregSel   = loSel_reg;

	// Sequencing and deferred switch-off
	chk_conv_start: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(convEnable) |-> $past(batteryAboveLockout) && $past(wakeHigh))
		else $error("converter started without lockout clear and wake");

	chk_conv_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		convEnable && batteryAboveLockout && !off_reg |=> convEnable)
		else $error("converter stopped before switch-off executed");

	chk_conv_off: assert property (@(posedge mclk) disable iff (!reset_n)
		off_reg |=> !convEnable)
		else $error("converter still on after switch-off");

	chk_ign_follow: assert property (@(posedge mclk) disable iff (!reset_n)
		ignitionFlag == $past(batteryAboveLockout))
		else $error("ignition flag does not follow battery");

	chk_sleep_delay: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(wakeHigh) && sleepResetActive |-> sleepResetActive[*8])
		else $error("sleep reset released too early");

	chk_off_defer: assert property (@(posedge mclk) disable iff (!reset_n)
		wakeHigh && !off_reg |=> !off_reg)
		else $error("switch-off executed while wake high");

	chk_pend_take: assert property (@(posedge mclk) disable iff (!reset_n)
		convOffCmd && wakeHigh && !sleepResetActive |=> offPending)
		else $error("converter-off command not latched");

	chk_glitch_keep: assert property (@(posedge mclk) disable iff (!reset_n)
		pend_reg && !wakeHigh && !lowDone && !off_reg |=> !off_reg)
		else $error("short wake low executed switch-off");

	chk_off_exec: assert property (@(posedge mclk) disable iff (!reset_n)
		lowDone && !wakeHigh && !off_reg |=> off_reg ##1 !convEnable)
		else $error("qualified wake low did not turn off");

	chk_low_restart: assert property (@(posedge mclk) disable iff (!reset_n)
		wakeHigh |=> !lowDone)
		else $error("wake-low count not restarted by wake high");

	// Supply lockout and source selection
	chk_core_need: assert property (@(posedge mclk) disable iff (!reset_n)
		coreSupplyEnable |-> $past(stepDownGoodCmp))
		else $error("core supply started without buck good");

	chk_core_lock: assert property (@(posedge mclk) disable iff (!reset_n)
		!stepDownGoodCmp && !internalReset |=> ##1 !coreSupplyEnable)
		else $error("core supply on without buck good");

	chk_lock_set: assert property (@(posedge mclk) disable iff (!reset_n)
		!stepDownGoodCmp && !internalReset |=> lock_reg)
		else $error("core lockout not set on buck bad");

	chk_lock_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		lock_reg && !internalReset |=> lock_reg)
		else $error("core lockout cleared without internal reset");

	chk_hi_sel: assert property (@(posedge mclk) disable iff (!reset_n)
		internalReset |=> switchPreregSel == pms_pkg::POS_0)
		else $error("switch pre-regulator not at position 0 in reset");

	chk_hi_boost: assert property (@(posedge mclk) disable iff (!reset_n)
		!internalReset && sleepMode_n && boostGood |=> switchPreregSel == pms_pkg::POS_2)
		else $error("switch pre-regulator not on boost source");

	chk_lo_sel: assert property (@(posedge mclk) disable iff (!reset_n)
		!sleepMode_n && !wakeHigh |=> logicPreregSel == pms_pkg::POS_0)
		else $error("logic pre-regulator not at position 0");

	chk_lo_buck: assert property (@(posedge mclk) disable iff (!reset_n)
		sleepMode_n && stepDownGoodCmp |=> logicPreregSel == pms_pkg::POS_2)
		else $error("logic pre-regulator not on buck source");

	chk_cap_off: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(logicRegEnable) |-> !logicRegEnable[*2] ##1 1'b1)
		else $error("logic regulator off pulse too short");
endmodule
`default_nettype wire

// ==== design/pms_pkg.sv ====
// Purpose: constants for the power mode sequencer
// Assumes: mclk at 250 MHz
// Notes: selector positions are two-bit codes
// Summary of operation
// - Converters start on lockout-clear and wake high
// - Ignition flag mirrors battery above lockout threshold
// - Sleep reset held 10 ms after wake
// - Converter-off command latched until wake low
// - Wake low under 1 ms discards execution
// - Wake low over 1 ms executes switch-off
// - Internal active-low sleep-mode signal derived
// - Core supply starts only with buck good
// - Buck-bad lockout held until internal reset
// - Switch pre-regulator source from truth table
// - Logic pre-regulator source from truth table
// - Logic regulator off 6 us every 200 ms
package pms_pkg;
	localparam int CLK_MHZ          = 250;
	localparam int SLEEP_RST_MS     = 10;
	localparam int WAKE_LOW_US      = 1000;
	localparam int CAP_PERIOD_MS    = 200;
	localparam int CAP_OFF_NS       = 6000;
	localparam int SLEEP_RST_CYC    = SLEEP_RST_MS * 1000 * CLK_MHZ;
	localparam int WAKE_LOW_CYC     = WAKE_LOW_US * CLK_MHZ;
	localparam int CAP_PERIOD_CYC   = CAP_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int CAP_OFF_CYC      = (CAP_OFF_NS * CLK_MHZ) / 1000;
	localparam logic [1:0] POS_0    = 2'h0;
	localparam logic [1:0] POS_1    = 2'h1;
	localparam logic [1:0] POS_2    = 2'h2;
endpackage

// ==== design/pms_timer.sv ====
// Purpose: restartable cycle counter with terminal flag
// Assumes: count held at zero while run is low
// Notes: done stays high while run persists past terminal
`timescale 1ns/1ps
`default_nettype none
module pms_timer #(
	parameter int LIMIT = 4
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// Control
	input  wire logic run,
	// Status
	output logic      done
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);
	logic [W-1:0] cnt_reg;
	wire          atEnd = (cnt_reg == LIM);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			cnt_reg <= '0;
		else if (!run)
			cnt_reg <= '0;
		else if (!atEnd)
			cnt_reg <= cnt_reg + W'(1);
	end
	assign done = atEnd;
endmodule
`default_nettype wire

// ==== dv/pms_far_side.sv ====
// Purpose: far-side rails and comparators for the power mode sequencer
// Assumes: rails settle two cycles after converter enable
// Notes: fault inputs let the bench pull either rail down
`timescale 1ns/1ps
`default_nettype none
module pms_far_side (
	// Clock
	input  wire logic mclk,
	// Converter enable and injected faults
	input  wire logic convEnable,
	input  wire logic boostFault,
	input  wire logic buckFault,
	// Comparators
	output logic      boostGood,
	output logic      stepDownGoodCmp
);
	logic [1:0] rampReg = 2'h0;
	// Host readback order is not modelled, only rail settling
	always @(posedge mclk) begin
		rampReg <= {rampReg[0], convEnable};
	end
	assign boostGood       = rampReg[1] & ~boostFault;
	assign stepDownGoodCmp = rampReg[1] & ~buckFault;
endmodule
`default_nettype wire

// ==== dv/power_mode_sequencer_tb.sv ====
// Purpose: self-checking bench for the power mode sequencer
// Assumes: shortened delays, rails from the far-side model
// Notes: selector tables are checked every cycle once enabled
`timescale 1ns/1ps
`default_nettype none
module power_mode_sequencer_tb;
	localparam int SR = 20, WL = 10, CP = 50, CO = 3;
	logic mclk = 0, reset_n = 0, wake = 0, batt = 0, iRst = 0, offCmd = 0, bF = 0, kF = 0;
	logic chkOn = 0, conv, core, lreg, srAct, sleepN, pend, ignition_flag, bg, kg, eIgn;
	logic [1:0] swSel, lgSel, eSw, eLg;
	logic [31:0] rnd;
	int n_mismatch = 0, comparisons = 0, seed = 35411, cnt;
	always #2 mclk = ~mclk;
	pms_power_mode_sequencer #(.SLEEP_RST_CYC(SR), .WAKE_LOW_CYC(WL), .CAP_PERIOD_CYC(CP),
		.CAP_OFF_CYC(CO)) DUT (.mclk(mclk), .reset_n(reset_n), .wakeHigh(wake),
		.batteryAboveLockout(batt), .boostGood(bg), .stepDownGoodCmp(kg), .internalReset(iRst),
		.convOffCmd(offCmd), .convEnable(conv), .coreSupplyEnable(core), .logicRegEnable(lreg),
		.sleepResetActive(srAct), .sleepMode_n(sleepN), .offPending(pend), .ignitionFlag(ignition_flag),
		.switchPreregSel(swSel), .logicPreregSel(lgSel));
	pms_far_side farSide (.mclk(mclk), .convEnable(conv), .boostFault(bF), .buckFault(kF),
		.boostGood(bg), .stepDownGoodCmp(kg));
	function automatic logic [1:0] swExp(logic r, logic s, logic b);
		return r ? 2'h0 : (!s ? 2'h1 : (b ? 2'h2 : 2'h1));
	endfunction
	function automatic logic [1:0] lgExp(logic w, logic s, logic k);
		return !s ? {1'b0, w} : (k ? 2'h2 : 2'h1);
	endfunction
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic pulseIrst;
		iRst <= 1;
		@(posedge mclk);
		iRst <= 0;
		repeat (5) @(posedge mclk);
	endtask
	// Inputs sampled at the edge are the ones the design saw
	always @(posedge mclk) begin
		if (chkOn) begin
			eSw = swExp(iRst, sleepN, bg);
			eLg = lgExp(wake, sleepN, kg);
			eIgn = batt;
			#1 chk(swSel, eSw);
			chk(lgSel, eLg);
			chk(ignition_flag, eIgn);
			chk(sleepN, !srAct);
		end
	end
	initial begin
		#20000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1;
		@(posedge mclk);
		chkOn <= 1;
		cnt = 0;
		repeat (2 * CP) begin
			@(posedge mclk);
			#1 cnt += !lreg;
		end
		chk(cnt == 2 * CO, 1);
		batt <= 1;
		wake <= 1;
		repeat (SR - 2) @(posedge mclk);
		#1 chk(srAct, 1);
		repeat (5) @(posedge mclk);
		#1 chk(srAct, 0);
		chk(conv, 1);
		pulseIrst();
		#1 chk(core, 1);
		kF <= 1;
		repeat (4) @(posedge mclk);
		#1 chk(core, 0);
		kF <= 0;
		repeat (4) @(posedge mclk);
		#1 chk(core, 0);
		pulseIrst();
		#1 chk(core, 1);
		offCmd <= 1;
		@(posedge mclk);
		offCmd <= 0;
		repeat (2) @(posedge mclk);
		#1 chk(pend, 1);
		chk(conv, 1);
		wake <= 0;
		repeat (WL - 3) @(posedge mclk);
		wake <= 1;
		repeat (2) @(posedge mclk);
		wake <= 0;
		repeat (WL - 3) @(posedge mclk);
		#1 chk(conv, 1);
		chk(pend, 1);
		repeat (6) @(posedge mclk);
		#1 chk(conv, 0);
		repeat (80) begin
			@(posedge mclk);
			rnd = $random(seed);
			{batt, wake, bF, kF, iRst, offCmd} <= rnd[5:0];
		end
		give_verdict();
	end
endmodule
`default_nettype wire
